// ===== design/pulse_width_dimming_decoder.sv
// Single-wire brightness programming logic of a boost LED driver.
// Assumes an open-drain host pulling dimming_line low; pins are asynchronous.
`timescale 1ns/10ps

// Overview of operation
// - Line idles high; only low pulses of chosen length carry symbols.
// - Low between 15 and 45 us decodes as a one bit.
// - Low between 90 and 120 us decodes as a zero bit.
// - Low over 215 us loads last five bits into brightness register.
// - Brightness is a 5-bit code selecting one of 32 levels.
// - Register clears to zero while disabled or under undervoltage lockout.
// - Enable low powers down and loses setting; host must reprogram.
// - Enable is active high.
// - Feedback reference rises linearly with code 0 to 31, default 0.
// - Overvoltage stops switching until output falls 7% below threshold.
module pulse_width_dimming_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic undervoltage_lockout,
    input wire logic dimming_line,
    input wire logic overvoltage_trip,
    input wire logic overvoltage_recovered,
    input wire logic switch_request,
    output logic [4:0] brightness_code,
    output logic [5:0] reference_step,
    output logic switch_node_gate,
    output logic feedback_disconnect_switch,
    output logic powered_down,
    output logic [1:0] last_symbol
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic line_lvl;
    logic en_lvl;
    logic undervoltage_lockout_lvl;
    logic ovp_lvl;
    logic ovr_lvl;

    pin_sync #(.RESET_VAL(1'b1)) u_line (.clock(clock), .rst(rst), .pin(dimming_line), .level(line_lvl));
    pin_sync #(.RESET_VAL(1'b0)) u_en (.clock(clock), .rst(rst), .pin(enable), .level(en_lvl));
    pin_sync #(.RESET_VAL(1'b1)) u_undervoltage_lockout (.clock(clock), .rst(rst), .pin(undervoltage_lockout), .level(undervoltage_lockout_lvl));
    pin_sync #(.RESET_VAL(1'b0)) u_ovp (.clock(clock), .rst(rst), .pin(overvoltage_trip), .level(ovp_lvl));
    pin_sync #(.RESET_VAL(1'b0)) u_ovr (.clock(clock), .rst(rst),
        .pin(overvoltage_recovered), .level(ovr_lvl));

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    // Enable is high-true; undervoltage also holds shifter, code, overvoltage latch and gate cleared
    wire active = en_lvl & ~undervoltage_lockout_lvl;

    // ----------------------------------------
    // Line edge and low-time counter
    // ----------------------------------------
    logic [13:0] low_cnt_r;
    logic [13:0] low_cnt_nxt;
    logic line_prev_r;
    logic cnt_full;

    // Previous level resets high, the idle level, so reset never fakes an edge
    wire rise = line_lvl & ~line_prev_r;
    wire is_low = ~line_lvl;

    // Saturates so a line stuck low can never wrap into a short pulse
    assign cnt_full = (low_cnt_r == dim_pkg::CNT_SAT);
    assign low_cnt_nxt = !is_low ? 14'h0000 :
        cnt_full ? low_cnt_r :
        low_cnt_r + 14'h0001;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            low_cnt_r <= 14'h0000;
            line_prev_r <= 1'b1;
        end
        else
        begin
            low_cnt_r <= low_cnt_nxt;
            line_prev_r <= line_lvl;
        end
    end

    // ----------------------------------------
    // Symbol classification
    // ----------------------------------------
    // Windows are open at both ends; counts are whole cycles low
    function automatic dim_pkg::symbol_e classify(input logic [13:0] n);
        if (n > 14'(dim_pkg::LOAD_MIN_CYC))
            classify = dim_pkg::SYM_LOAD;
        else if (n > 14'(dim_pkg::ZERO_MIN_CYC) && n < 14'(dim_pkg::ZERO_MAX_CYC))
            classify = dim_pkg::SYM_ZERO;
        else if (n > 14'(dim_pkg::ONE_MIN_CYC) && n < 14'(dim_pkg::ONE_MAX_CYC))
            classify = dim_pkg::SYM_ONE;
        else
            classify = dim_pkg::SYM_NONE;
    endfunction

    // Pulses that end while powered down are dropped
    dim_pkg::symbol_s sym;
    logic take_one;
    logic take_zero;
    logic take_load;

    assign sym.valid = rise & active;
    assign sym.kind = classify(low_cnt_r);
    assign take_one = sym.valid && (sym.kind == dim_pkg::SYM_ONE);
    assign take_zero = sym.valid && (sym.kind == dim_pkg::SYM_ZERO);
    assign take_load = sym.valid && (sym.kind == dim_pkg::SYM_LOAD);

    // Out-of-window pulses still report, as code 0, for visibility
    always_ff @(posedge clock)
    begin
        if (rst)
            last_symbol <= 2'h0;
        else if (sym.valid)
            last_symbol <= sym.kind;
    end

    // ----------------------------------------
    // Bit shifter
    // ----------------------------------------
    logic [4:0] shift_r;
    logic [4:0] shift_nxt;

    // Earliest bit ends up in the MSB after five shifts
    // Fewer than five bits leave older bits in the upper end
    assign shift_nxt = !active ? dim_pkg::CODE_RESET :
        take_one ? {shift_r[3:0], 1'b1} :
        take_zero ? {shift_r[3:0], 1'b0} :
        shift_r;

    always_ff @(posedge clock)
    begin
        if (rst)
            shift_r <= dim_pkg::CODE_RESET;
        else
            shift_r <= shift_nxt;
    end

    // ----------------------------------------
    // Brightness register
    // ----------------------------------------
    logic [4:0] code_r;
    logic [4:0] code_nxt;
    logic [5:0] ref_nxt;

    // A load copies the shifter as it stands, so a bare load repeats old bits
    assign code_nxt = !active ? dim_pkg::CODE_RESET :
        take_load ? shift_r :
        code_r;

    // Index 1..32 keeps a small nonzero reference at code 0
    assign ref_nxt = {1'b0, code_nxt} + 6'h01;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            code_r <= dim_pkg::CODE_RESET;
            brightness_code <= dim_pkg::CODE_RESET;
            reference_step <= 6'h00;
        end
        else
        begin
            code_r <= code_nxt;
            brightness_code <= code_nxt;
            reference_step <= ref_nxt;
        end
    end

    // ----------------------------------------
    // Overvoltage gating
    // ----------------------------------------
    logic ovp_hold_r;
    logic ovp_hold_nxt;
    logic gate_nxt;

    // Hysteresis is analog; two comparator levels arrive here
    // A trip wins over recovery when both are seen in one cycle
    assign ovp_hold_nxt = !active ? 1'b0 :
        ovp_lvl ? 1'b1 :
        ovr_lvl ? 1'b0 :
        ovp_hold_r;

    // Request comes from the regulator on this clock, so no synchroniser
    assign gate_nxt = active & switch_request & ~ovp_hold_nxt;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ovp_hold_r <= 1'b0;
            switch_node_gate <= 1'b0;
        end
        else
        begin
            ovp_hold_r <= ovp_hold_nxt;
            switch_node_gate <= gate_nxt;
        end
    end

    // ----------------------------------------
    // Power-down outputs
    // ----------------------------------------
    // Overvoltage never reaches these; it only blanks the switch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            feedback_disconnect_switch <= 1'b0;
            powered_down <= 1'b1;
        end
        else
        begin
            feedback_disconnect_switch <= active;
            powered_down <= ~active;
        end
    end

    // Gap check is the host's duty: 3 us is far above the pin latency

endmodule

// ===== design/dim_pkg.sv
// Package for the pulse-width dimming decoder.
// Assumes a 50 MHz system clock; all times are converted to cycles here.
package dim_pkg;

    localparam int CLOCK_HZ = 50_000_000;

    // ----------------------------------------
    // Pulse timing (ns, as specified)
    // ----------------------------------------
    localparam int ONE_MIN_NS = 15_000;
    localparam int ONE_MAX_NS = 45_000;
    localparam int ZERO_MIN_NS = 90_000;
    localparam int ZERO_MAX_NS = 120_000;
    localparam int LOAD_MIN_NS = 215_000;
    localparam int HIGH_MIN_NS = 3_000;
    localparam int CLOCK_NS = 1_000_000_000 / CLOCK_HZ;

    // Least times round up, longest round down
    localparam int ONE_MIN_CYC = (ONE_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int ONE_MAX_CYC = ONE_MAX_NS / CLOCK_NS;
    localparam int ZERO_MIN_CYC = (ZERO_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int ZERO_MAX_CYC = ZERO_MAX_NS / CLOCK_NS;
    localparam int LOAD_MIN_CYC = (LOAD_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int HIGH_MIN_CYC = (HIGH_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int CODE_W = 5;
    localparam int CNT_W = 14;
    localparam logic [4:0] CODE_RESET = 5'h00;
    localparam logic [13:0] CNT_SAT = 14'h3FFF;

    typedef enum logic [1:0] {
        SYM_NONE = 2'b00,
        SYM_ONE = 2'b01,
        SYM_ZERO = 2'b10,
        SYM_LOAD = 2'b11
    } symbol_e;

    typedef struct packed {
        logic valid;
        symbol_e kind;
    } symbol_s;

endpackage

// ===== design/pin_sync.sv
// Three-stage synchroniser for asynchronous pins.
// A change is accepted once the second and third stages agree.
`timescale 1ns/10ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    output logic level
);

    logic meta_r;
    logic mid_r;
    logic last_r;
    logic level_r;
    wire agree = (mid_r == last_r);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta_r <= RESET_VAL;
            mid_r <= RESET_VAL;
            last_r <= RESET_VAL;
            level_r <= RESET_VAL;
        end
        else
        begin
            meta_r <= pin;
            mid_r <= meta_r;
            last_r <= mid_r;
            if (agree)
                level_r <= last_r;
        end
    end

    assign level = level_r;

endmodule

// ===== dv/dim_sva.sv
// Port checker for the dimming decoder.
// Assumes pins pass a short synchroniser of a few cycles.
`timescale 1ns/10ps
module dim_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic undervoltage_lockout,
    input wire logic dimming_line,
    input wire logic overvoltage_trip,
    input wire logic switch_request,
    input wire logic [4:0] brightness_code,
    input wire logic [5:0] reference_step,
    input wire logic switch_node_gate,
    input wire logic feedback_disconnect_switch,
    input wire logic powered_down
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_clear_off: assert property (powered_down |=> brightness_code == 5'h00)
        else $error("code not cleared while off");
    a_ref_linear: assert property (!powered_down && $past(!powered_down) && $stable(brightness_code)
        |-> reference_step == {1'b0, brightness_code} + 6'h01) else $error("reference not code plus one");
    a_gate_cause: assert property (switch_node_gate |-> $past(switch_request) && !powered_down)
        else $error("gate without request");
    a_ovp_stop: assert property (overvoltage_trip [*8] |-> !switch_node_gate)
        else $error("gate during overvoltage");
    a_feedback_disconnect_switch_off: assert property (powered_down |-> !feedback_disconnect_switch)
        else $error("feedback switch closed while off");
    a_enable_low: assert property (!enable [*8] |-> powered_down)
        else $error("enable low not powered down");
    a_undervoltage_lockout_off: assert property (undervoltage_lockout [*8] |-> powered_down)
        else $error("lockout not powered down");
    a_load_rise: assert property (!powered_down && $changed(brightness_code) |-> dimming_line)
        else $error("code moved while line low");
    a_hold_low: assert property (!dimming_line [*8] |=> $stable(brightness_code) || powered_down)
        else $error("code moved during low pulse");
endmodule
bind pulse_width_dimming_decoder dim_sva chk (.clock(clock), .rst(rst), .enable(enable),
    .undervoltage_lockout(undervoltage_lockout), .dimming_line(dimming_line),
    .overvoltage_trip(overvoltage_trip), .switch_request(switch_request), .brightness_code(brightness_code),
    .reference_step(reference_step), .switch_node_gate(switch_node_gate),
    .feedback_disconnect_switch(feedback_disconnect_switch), .powered_down(powered_down));

// ===== dv/host_model.sv
// Open-drain host that pulses the dimming line low.
// Assumes a pull-up: a released line reads high.
`timescale 1ns/10ps
module host_model (
    input wire logic clock,
    output logic dimming_line
);
    logic pull_low = 1'b0;
    assign dimming_line = pull_low ? 1'b0 : 1'b1;
    // One low pulse, then a 4 us release
    task automatic send(input int low_cyc);
        @(posedge clock);
        #1 pull_low = 1'b1;
        repeat (low_cyc) @(posedge clock);
        #1 pull_low = 1'b0;
        repeat (dim_pkg::HIGH_MIN_CYC + 50) @(posedge clock);
    endtask
    // First bit goes out first: 20 us one, 94 us zero, 220 us load
    task automatic send_code(input logic [4:0] c);
        for (int i = 4; i >= 0; i--)
            send(c[i] ? 1000 : 4700);
        send(11000);
    endtask
endmodule

// ===== dv/pulse_width_dimming_decoder_tb.sv
// Testbench for the dimming decoder with an open-drain host model.
// Assumes a 50 MHz clock and up to six cycles of pin latency.
`timescale 1ns/10ps
module pulse_width_dimming_decoder_tb;
    logic clock, rst, enable, undervoltage_lockout;
    logic overvoltage_trip, overvoltage_recovered, switch_request;
    logic dimming_line, switch_node_gate, feedback_disconnect_switch, powered_down;
    logic [4:0] brightness_code;
    logic [5:0] reference_step;
    logic [1:0] last_symbol;
    int fails = 0, n_tests = 0;
    host_model host (.clock(clock), .dimming_line(dimming_line));
    pulse_width_dimming_decoder dut (.clock(clock), .rst(rst), .enable(enable),
        .undervoltage_lockout(undervoltage_lockout), .dimming_line(dimming_line),
        .overvoltage_trip(overvoltage_trip), .overvoltage_recovered(overvoltage_recovered),
        .switch_request(switch_request), .brightness_code(brightness_code), .reference_step(reference_step),
        .switch_node_gate(switch_node_gate), .feedback_disconnect_switch(feedback_disconnect_switch),
        .powered_down(powered_down), .last_symbol(last_symbol));
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic settle();
        repeat (20) @(posedge clock);
        #1;
    endtask
    task automatic t_walk();
        host.send_code(5'h14);
        settle();
        chk("code", 8'h14, brightness_code);
        chk("ref", 8'h15, reference_step);
        $display("walk done");
    endtask
    task automatic t_ignore();
        host.send(1000);
        host.send(3000);
        chk("sym", 8'h00, last_symbol);
        repeat (4) host.send(1000);
        host.send(11000);
        settle();
        chk("code", 8'h1F, brightness_code);
        $display("ignore done");
    endtask
    task automatic t_ovp();
        settle();
        chk("gate", 8'h01, switch_node_gate);
        chk("feedback_disconnect_switch", 8'h01, feedback_disconnect_switch);
        switch_request = 1'b0;
        settle();
        chk("gate", 8'h00, switch_node_gate);
        switch_request = 1'b1;
        overvoltage_trip = 1'b1;
        settle();
        chk("gate", 8'h00, switch_node_gate);
        overvoltage_recovered = 1'b0;
        overvoltage_trip = 1'b0;
        settle();
        chk("gate", 8'h00, switch_node_gate);
        overvoltage_recovered = 1'b1;
        settle();
        chk("gate", 8'h01, switch_node_gate);
        chk("pd", 8'h00, powered_down);
        $display("ovp done");
    endtask
    task automatic t_off();
        undervoltage_lockout = 1'b1;
        settle();
        chk("code", 8'h00, brightness_code);
        chk("pd", 8'h01, powered_down);
        undervoltage_lockout = 1'b0;
        settle();
        host.send(1000);
        host.send(11000);
        settle();
        chk("code", 8'h01, brightness_code);
        enable = 1'b0;
        settle();
        chk("pd", 8'h01, powered_down);
        chk("feedback_disconnect_switch", 8'h00, feedback_disconnect_switch);
        chk("code", 8'h00, brightness_code);
        enable = 1'b1;
        settle();
        chk("code", 8'h00, brightness_code);
        $display("off done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        enable = 1'b1;
        undervoltage_lockout = 1'b0;
        overvoltage_trip = 1'b0;
        overvoltage_recovered = 1'b1;
        switch_request = 1'b1;
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        repeat (10) @(posedge clock);
        t_walk();
        t_ignore();
        t_ovp();
        t_off();
        print_verdict();
    end
endmodule
